/* File: rtl/vso_defs.svh */
// Constants for the video sync output port: widths, counts and thresholds.
`ifndef VSO_DEFS_SVH
`define VSO_DEFS_SVH

`define VSO_DATA_W      8
`define VSO_WORD_W      12
`define VSO_FIFO_DEPTH  8
`define VSO_LINE_PERIOD 11'h6b4
`define VSO_HS_WIDTH    7'h40
`define VSO_LL_NORMAL   8'h49
`define VSO_LL_GONE     8'h89
`define VSO_VS_LINES    2'h3
`define VSO_PIN_W       11

`endif

/* File: rtl/vso_fifo.sv */
// Dual-clock sample buffer with gray-coded pointers.
`timescale 1ns/100ps
`include "vso_defs.svh"
module vso_fifo #(
	parameter int WIDTH = `VSO_WORD_W,
	parameter int DEPTH = `VSO_FIFO_DEPTH
) (
	input  wire logic wrClk,
	input  wire logic wrRst,
	input  wire logic rdClk,
	input  wire logic rdRst,
	vso_fifo_if.fifo  port
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW:0]      wrBin_q;
	logic [AW:0]      wrGray_q;
	logic [AW:0]      rdBin_q;
	logic [AW:0]      rdGray_q;
	logic [AW:0]      rdGrayS1_q;
	logic [AW:0]      rdGrayS_q;
	logic [AW:0]      wrGrayS1_q;
	logic [AW:0]      wrGrayS_q;
	logic [AW:0]      wrBinNext;
	logic [AW:0]      rdBinNext;
	logic             wrFire;
	logic             rdFire;

	// Full compares against the read pointer seen two flops late.
	assign port.wrReady = (wrGray_q !=
		{~rdGrayS_q[AW:AW-1], rdGrayS_q[AW-2:0]});
	assign port.rdValid = (rdGray_q != wrGrayS_q);
	assign port.rdData  = mem_q[rdBin_q[AW-1:0]];
	assign wrFire    = port.wrValid & port.wrReady;
	assign rdFire    = port.rdValid & port.rdReady;
	assign wrBinNext = wrBin_q + 1'b1;
	assign rdBinNext = rdBin_q + 1'b1;

	// Write pointer and storage, producer side.
	always_ff @(posedge wrClk) begin
		if (wrRst) begin
			wrBin_q  <= '0;
			wrGray_q <= '0;
		end else if (wrFire) begin
			mem_q[wrBin_q[AW-1:0]] <= port.wrData;
			wrBin_q  <= wrBinNext;
			wrGray_q <= wrBinNext ^ (wrBinNext >> 1);
		end
	end

	// Read pointer brought over to the producer side.
	always_ff @(posedge wrClk) begin
		if (wrRst) begin
			rdGrayS1_q <= '0;
			rdGrayS_q  <= '0;
		end else begin
			rdGrayS1_q <= rdGray_q;
			rdGrayS_q  <= rdGrayS1_q;
		end
	end

	// Read pointer, consumer side.
	always_ff @(posedge rdClk) begin
		if (rdRst) begin
			rdBin_q  <= '0;
			rdGray_q <= '0;
		end else if (rdFire) begin
			rdBin_q  <= rdBinNext;
			rdGray_q <= rdBinNext ^ (rdBinNext >> 1);
		end
	end

	// Write pointer brought over to the consumer side.
	always_ff @(posedge rdClk) begin
		if (rdRst) begin
			wrGrayS1_q <= '0;
			wrGrayS_q  <= '0;
		end else begin
			wrGrayS1_q <= wrGray_q;
			wrGrayS_q  <= wrGrayS1_q;
		end
	end

	chk_wr_stall_holds: assert property (@(posedge wrClk) disable iff (wrRst)
		port.wrValid && !port.wrReady |=> $stable(wrBin_q))
		else $error("write pointer moved while buffer full");
	chk_rd_fire_moves: assert property (@(posedge rdClk) disable iff (rdRst)
		rdFire |=> rdBin_q == $past(rdBin_q) + 1'b1)
		else $error("read pointer did not advance on a read");
endmodule // vso_fifo

/* File: rtl/vso_fifo_if.sv */
// Interface joining the sample buffer to its producer and consumer.
`timescale 1ns/100ps
interface vso_fifo_if #(parameter int W = 12);
	logic         wrValid;
	logic         wrReady;
	logic [W-1:0] wrData;
	logic         rdValid;
	logic         rdReady;
	logic [W-1:0] rdData;

	modport fifo (input wrValid, input wrData, output wrReady,
		output rdValid, output rdData, input rdReady);
	modport client (output wrValid, output wrData, input wrReady,
		input rdValid, input rdData, output rdReady);
endinterface

/* File: rtl/vso_pkg.sv */
// Types shared by the video sync output port modules.
package vso_pkg;

	// Kind of word carried through the sample buffer.
	typedef enum logic [1:0] {
		VSO_KIND_VIDEO = 2'b00,
		VSO_KIND_FIELD = 2'b01,
		VSO_KIND_FREQ  = 2'b10,
		VSO_KIND_PHASE = 2'b11
	} vso_kind_t;

	// One buffered word: kind, field flags and the byte for the bus.
	typedef struct packed {
		vso_kind_t   kind;
		logic        burstBlank;
		logic        fieldParity;
		logic [7:0]  data;
	} vso_word_t;

	// Horizontal sync pulse generator states.
	typedef enum logic {
		VSO_HS_IDLE  = 1'b0,
		VSO_HS_PULSE = 1'b1
	} vso_hs_state_t;

endpackage

/* File: rtl/vso_top.sv */
// Video sync output port: pixel clock, sync outputs and composite bus.
`timescale 1ns/100ps
`include "vso_defs.svh"
module vso_top (
	input  wire logic              core_clk,
	input  wire logic              reset,
	input  wire logic              internalDoubleClock,
	input  wire logic              externalDoubleClockIn,
	input  wire logic              clockSourceSelect,
	input  wire logic              refHsyncIn,
	input  wire logic              refVsyncIn,
	input  wire logic              videoLocked,
	input  wire logic [7:0]        phaseErrorSetting,
	input  wire logic              srcValid,
	output logic                   srcReady,
	input  wire vso_pkg::vso_kind_t srcKind,
	input  wire logic [7:0]        srcData,
	input  wire logic              srcFieldParity,
	input  wire logic              srcBurstBlank,
	output logic                   doublePixelClock,
	output logic                   pixelRateClockOut,
	output logic                   horizontalSyncOut,
	output logic                   verticalSyncOut,
	output logic [7:0]             compositeOutputBus,
	output logic                   fieldParityFlag,
	output logic                   burstBlankFlag,
	output logic                   outputEnable
);
	import vso_pkg::*;

	logic                  selSync1_q;
	logic                  selSync_q;
	logic                  dblClk;
	logic                  linkRst1_q;
	logic                  linkRst_q;
	logic [`VSO_PIN_W-1:0] pinS1_q;
	logic [`VSO_PIN_W-1:0] pinS2_q;
	logic                  hsPrev_q;
	logic                  vsPrev_q;
	logic                  lockedS;
	logic                  hsInS;
	logic                  vsInS;
	logic [7:0]            leadLagS;
	logic                  hsFall;
	logic                  vsFall;
	logic                  pixClk_q;
	logic [10:0]           lineCnt_q;
	logic [2:0]            pulseIdx_q;
	logic [6:0]            hsCnt_q;
	vso_hs_state_t         hsState_q;
	logic                  hsStart;
	logic [6:0]            hsWidth;
	logic                  hsOut_q;
	logic                  vsOut_q;
	logic [1:0]            vsLines_q;
	vso_word_t             rdWord;
	logic                  kindMatch;
	logic                  rdFire;
	logic [7:0]            bus_q;
	logic                  fp_q;
	logic                  bb_q;
	logic                  oe_q;
	logic [6:0]            lowCnt_q;

	vso_fifo_if #(.W(`VSO_WORD_W)) fIf ();

	// Width of the eighth free-running pulse from the phase error setting.
	function automatic logic [6:0] eighthWidth(input logic [7:0] ll);
		logic [7:0] diff;
		diff = `VSO_LL_GONE - ll;
		if (ll <= `VSO_LL_NORMAL)
			eighthWidth = `VSO_HS_WIDTH;
		else if (ll >= `VSO_LL_GONE)
			eighthWidth = 7'h00;
		else
			eighthWidth = diff[6:0];
	endfunction

	// Source select pin passes two flops; reset picks the internal clock.
	always_ff @(posedge core_clk) begin
		if (reset) begin
			selSync1_q <= 1'b1;
			selSync_q  <= 1'b1;
		end else begin
			selSync1_q <= clockSourceSelect;
			selSync_q  <= selSync1_q;
		end
	end

	// Clock source mux; a select change may leave one short clock phase.
	assign dblClk = selSync_q ? internalDoubleClock
		: externalDoubleClockIn;
	assign doublePixelClock = dblClk;

	// Producer side of the sample buffer runs on the core clock.
	assign fIf.wrValid = srcValid;
	assign fIf.wrData  = {srcKind, srcBurstBlank, srcFieldParity, srcData};
	assign srcReady    = fIf.wrReady;

	vso_fifo #(
		.WIDTH (`VSO_WORD_W),
		.DEPTH (`VSO_FIFO_DEPTH)
	) i_vso_fifo (
		.wrClk (core_clk),
		.wrRst (reset),
		.rdClk (dblClk),
		.rdRst (linkRst_q),
		.port  (fIf.fifo)
	);

	// Reset level carried into the link clock domain.
	always_ff @(posedge dblClk) begin
		linkRst1_q <= reset;
		linkRst_q  <= linkRst1_q;
	end

	// Video front-end pins pass two flops before any logic reads them.
	always_ff @(posedge dblClk) begin
		if (linkRst_q) begin
			pinS1_q <= '0;
			pinS2_q <= '0;
		end else begin
			pinS1_q <= {videoLocked, refVsyncIn, refHsyncIn,
				phaseErrorSetting};
			pinS2_q <= pinS1_q;
		end
	end

	assign lockedS  = pinS2_q[10];
	assign vsInS    = pinS2_q[9];
	assign hsInS    = pinS2_q[8];
	assign leadLagS = pinS2_q[7:0];
	assign hsFall   = hsPrev_q & ~hsInS;
	assign vsFall   = vsPrev_q & ~vsInS;

	// Previous synchronised sync levels for edge detection.
	always_ff @(posedge dblClk) begin
		if (linkRst_q) begin
			hsPrev_q <= 1'b1;
			vsPrev_q <= 1'b1;
		end else begin
			hsPrev_q <= hsInS;
			vsPrev_q <= vsInS;
		end
	end

	// Pixel rate clock is a toggle of the double clock.
	always_ff @(posedge dblClk) begin
		if (linkRst_q)
			pixClk_q <= 1'b0;
		else
			pixClk_q <= ~pixClk_q;
	end
	assign pixelRateClockOut = pixClk_q;

	// A pulse starts on each incoming fall when locked, else free-running.
	assign hsStart = lockedS ? hsFall
		: (lineCnt_q == `VSO_LINE_PERIOD - 11'h001);
	assign hsWidth = (!lockedS && pulseIdx_q == 3'h7)
		? eighthWidth(leadLagS) : `VSO_HS_WIDTH;

	// Line counter spaces free-running pulses evenly.
	always_ff @(posedge dblClk) begin
		if (linkRst_q)
			lineCnt_q <= '0;
		else if (hsStart)
			lineCnt_q <= '0;
		else if (lineCnt_q != `VSO_LINE_PERIOD - 11'h001)
			lineCnt_q <= lineCnt_q + 11'h001;
	end

	// Pulse index picks every eighth pulse.
	always_ff @(posedge dblClk) begin
		if (linkRst_q)
			pulseIdx_q <= '0;
		else if (hsStart)
			pulseIdx_q <= pulseIdx_q + 3'h1;
	end

	// Horizontal sync pulse state machine; a zero width drops the pulse.
	always_ff @(posedge dblClk) begin
		if (linkRst_q) begin
			hsState_q <= VSO_HS_IDLE;
			hsCnt_q   <= '0;
			hsOut_q   <= 1'b1;
		end else begin
			case (hsState_q)
				VSO_HS_IDLE: begin
					if (hsStart && hsWidth != 7'h00) begin
						hsState_q <= VSO_HS_PULSE;
						hsCnt_q   <= hsWidth - 7'h01;
						hsOut_q   <= 1'b0;
					end
				end
				VSO_HS_PULSE: begin
					if (hsCnt_q == 7'h00) begin
						hsState_q <= VSO_HS_IDLE;
						hsOut_q   <= 1'b1;
					end else begin
						hsCnt_q <= hsCnt_q - 7'h01;
					end
				end
				default: begin
					hsState_q <= VSO_HS_IDLE;
					hsOut_q   <= 1'b1;
				end
			endcase
		end
	end
	assign horizontalSyncOut = hsOut_q;

	// Vertical sync falls with the first vertical pulse, rises lines later.
	always_ff @(posedge dblClk) begin
		if (linkRst_q) begin
			vsOut_q   <= 1'b1;
			vsLines_q <= '0;
		end else if (!lockedS) begin
			vsOut_q   <= 1'b1;
			vsLines_q <= '0;
		end else if (vsFall && vsOut_q) begin
			vsOut_q   <= 1'b0;
			vsLines_q <= `VSO_VS_LINES;
		end else if (!vsOut_q && hsStart) begin
			if (vsLines_q == 2'h1)
				vsOut_q <= 1'b1;
			vsLines_q <= vsLines_q - 2'h1;
		end
	end
	assign verticalSyncOut = vsOut_q;

	// Consumer side: ancillary words only inside the sync pulse.
	assign rdWord    = fIf.rdData;
	assign kindMatch = hsOut_q ? (rdWord.kind == VSO_KIND_VIDEO)
		: (rdWord.kind != VSO_KIND_VIDEO);
	assign fIf.rdReady = pixClk_q & kindMatch;
	assign rdFire      = fIf.rdValid & fIf.rdReady;

	// Bus and flags change as the pixel clock falls, stable at its rise.
	always_ff @(posedge dblClk) begin
		if (linkRst_q) begin
			bus_q <= '0;
			fp_q  <= 1'b0;
			bb_q  <= 1'b0;
		end else if (rdFire) begin
			bus_q <= rdWord.data;
			fp_q  <= rdWord.fieldParity;
			bb_q  <= rdWord.burstBlank;
		end
	end
	assign compositeOutputBus = bus_q;
	assign fieldParityFlag    = fp_q;
	assign burstBlankFlag     = bb_q;

	// Outputs are disabled while the link side is held in reset.
	always_ff @(posedge dblClk) begin
		oe_q <= ~linkRst_q;
	end
	assign outputEnable = oe_q;

	// Length of the current low pulse, for checking only.
	always_ff @(posedge dblClk) begin
		if (linkRst_q || hsOut_q)
			lowCnt_q <= '0;
		else if (lowCnt_q != 7'h7f)
			lowCnt_q <= lowCnt_q + 7'h01;
	end

	chk_pixclk_half: assert property (@(posedge dblClk)
		disable iff (linkRst_q) pixClk_q |=> !pixClk_q ##1 pixClk_q)
		else $error("pixel clock is not half the double clock");
	chk_sel_follow: assert property (@(posedge core_clk)
		disable iff (reset) $past(clockSourceSelect, 2) == selSync_q)
		else $error("clock select did not follow the pin");
	chk_hs_locked: assert property (@(posedge dblClk)
		disable iff (linkRst_q)
		lockedS && hsFall && hsState_q == VSO_HS_IDLE |=> !hsOut_q)
		else $error("no sync pulse after incoming fall");
	chk_hs_source: assert property (@(posedge dblClk)
		disable iff (linkRst_q) lockedS && $fell(hsOut_q) |-> $past(hsFall))
		else $error("locked pulse without incoming sync");
	chk_free_even: assert property (@(posedge dblClk)
		disable iff (linkRst_q) !lockedS && hsStart && pulseIdx_q != 3'h7
		&& hsState_q == VSO_HS_IDLE |=> !hsOut_q)
		else $error("free-running pulse missing");
	chk_eighth_gone: assert property (@(posedge dblClk)
		disable iff (linkRst_q) !lockedS && hsStart && pulseIdx_q == 3'h7
		&& leadLagS >= 8'h89 && hsOut_q |=> hsOut_q)
		else $error("eighth pulse not dropped");
	chk_hs_width: assert property (@(posedge dblClk)
		disable iff (linkRst_q) lowCnt_q <= 7'h40)
		else $error("horizontal pulse too wide");
	chk_vs_fall: assert property (@(posedge dblClk)
		disable iff (linkRst_q) lockedS && vsFall && vsOut_q |=> !vsOut_q)
		else $error("vertical sync did not fall");
	chk_vs_nolock: assert property (@(posedge dblClk)
		disable iff (linkRst_q) !lockedS |=> vsOut_q)
		else $error("vertical sync low without lock");
	chk_bus_phase: assert property (@(posedge dblClk)
		disable iff (linkRst_q)
		rdFire |=> !pixClk_q && bus_q == $past(rdWord.data))
		else $error("bus not updated on pixel clock fall");
	chk_anc_kind: assert property (@(posedge dblClk)
		disable iff (linkRst_q)
		rdFire && !hsOut_q |-> rdWord.kind != VSO_KIND_VIDEO)
		else $error("video sample during sync pulse");
	chk_flag_follow: assert property (@(posedge dblClk)
		disable iff (linkRst_q) rdFire |=> fp_q == $past(rdWord.fieldParity)
		&& bb_q == $past(rdWord.burstBlank))
		else $error("field flags not taken from word");
	chk_oe_reset: assert property (@(posedge dblClk)
		linkRst_q |=> !outputEnable)
		else $error("outputs enabled during reset");

	cov_anc_word: cover property (@(posedge dblClk) rdFire && !hsOut_q);
	cov_eighth_short: cover property (@(posedge dblClk)
		!lockedS && hsStart && pulseIdx_q == 3'h7 && hsWidth < 7'h40
		&& hsWidth != 7'h00);
	cov_vs_pulse: cover property (@(posedge dblClk) $rose(vsOut_q));
	cov_fifo_full: cover property (@(posedge core_clk) srcValid && !srcReady);
endmodule // vso_top

/* File: verification/vso_sink_model.sv */
// Downstream receiver model that logs bytes taken from the composite bus.
`timescale 1ns/100ps
module vso_sink_model (
	input  wire logic       pixelRateClockOut,
	input  wire logic [7:0] compositeOutputBus,
	input  wire logic       horizontalSyncOut,
	input  wire logic       fieldParityFlag,
	input  wire logic       burstBlankFlag,
	input  wire logic       clearLog
);
	logic [7:0] seenData  [0:15];
	logic       seenHs    [0:15];
	logic       seenPar   [0:15];
	logic       seenBurst [0:15];
	int         seenIdx   [0:15];
	int         seenCnt;
	int         pixCnt;
	logic [7:0] lastData;

	// Captures on the pixel clock rise, where the bus has settled.
	always @(posedge pixelRateClockOut or posedge clearLog) begin
		if (clearLog) begin
			seenCnt = 0;
			pixCnt = 0;
			lastData = 8'h00;
		end else begin
			pixCnt++;
			if (compositeOutputBus !== lastData && seenCnt < 16) begin
				seenData[seenCnt] = compositeOutputBus;
				seenHs[seenCnt] = horizontalSyncOut;
				seenPar[seenCnt] = fieldParityFlag;
				// The burst flag only counts while field parity is high.
				seenBurst[seenCnt] = fieldParityFlag & burstBlankFlag;
				seenIdx[seenCnt] = pixCnt;
				seenCnt++;
				lastData = compositeOutputBus;
			end
		end
	end
endmodule // vso_sink_model

/* File: verification/vso_top_tb.sv */
// Self-checking bench for the video sync output port.
`timescale 1ns/100ps
module vso_top_tb;
	import vso_pkg::*;
	logic       core_clk, reset, internalDoubleClock, externalDoubleClockIn;
	logic       clockSourceSelect, refHsyncIn, refVsyncIn, videoLocked;
	logic [7:0] phaseErrorSetting, srcData, compositeOutputBus;
	logic       srcValid, srcReady, srcFieldParity, srcBurstBlank;
	vso_kind_t  srcKind;
	logic       doublePixelClock, pixelRateClockOut, horizontalSyncOut;
	logic       verticalSyncOut, fieldParityFlag, burstBlankFlag;
	logic       outputEnable, clearLog;
	int         error_cnt, checks_done;

	// Core clock at 20 ns, link clocks at 30 ns and 32 ns.
	always #10 core_clk = ~core_clk;
	always #15 internalDoubleClock = ~internalDoubleClock;
	always #16 externalDoubleClockIn = ~externalDoubleClockIn;

	vso_top i_vso_top (.core_clk(core_clk), .reset(reset),
		.internalDoubleClock(internalDoubleClock),
		.externalDoubleClockIn(externalDoubleClockIn),
		.clockSourceSelect(clockSourceSelect), .refHsyncIn(refHsyncIn),
		.refVsyncIn(refVsyncIn), .videoLocked(videoLocked),
		.phaseErrorSetting(phaseErrorSetting), .srcValid(srcValid),
		.srcReady(srcReady), .srcKind(srcKind), .srcData(srcData),
		.srcFieldParity(srcFieldParity), .srcBurstBlank(srcBurstBlank),
		.doublePixelClock(doublePixelClock),
		.pixelRateClockOut(pixelRateClockOut),
		.horizontalSyncOut(horizontalSyncOut),
		.verticalSyncOut(verticalSyncOut),
		.compositeOutputBus(compositeOutputBus),
		.fieldParityFlag(fieldParityFlag), .burstBlankFlag(burstBlankFlag),
		.outputEnable(outputEnable));

	vso_sink_model i_vso_sink_model (.pixelRateClockOut(pixelRateClockOut),
		.compositeOutputBus(compositeOutputBus),
		.horizontalSyncOut(horizontalSyncOut),
		.fieldParityFlag(fieldParityFlag), .burstBlankFlag(burstBlankFlag),
		.clearLog(clearLog));

	// Steps to just after the next core clock rise.
	task tick();
		@(posedge core_clk);
		#2;
	endtask

	// Prints the counts and the verdict, then ends the run.
	task conclude();
		$display("Checks %0d, mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Compares one value and reports a mismatch at once.
	task chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Counts link edges until a sync output reaches the given level.
	task wait_out(input bit useVs, input logic lvl, output int n);
		n = 0;
		while ((useVs ? verticalSyncOut : horizontalSyncOut) !== lvl) begin
			@(posedge doublePixelClock);
			#1;
			n++;
			if (n > 4000) begin
				error_cnt++;
				$display("[FAIL] sync wait expected %b seen timeout", lvl);
				conclude();
			end
		end
	endtask

	// Offers one word and holds it until the buffer takes it.
	task put_word(input vso_kind_t k, input logic [7:0] d, input logic p,
		input logic b);
		bit r;
		int n;
		srcKind = k;
		srcData = d;
		srcFieldParity = p;
		srcBurstBlank = b;
		srcValid = 1'b1;
		r = 1'b0;
		n = 0;
		while (!r) begin
			r = (srcReady === 1'b1);
			tick();
			n++;
			if (n > 50) begin
				chk("srcReady wait", 1, 0);
				conclude();
			end
		end
	endtask

	// One incoming line: sync pin low, latency and width of the output pulse.
	task ref_line(output int lat, output int w);
		tick();
		refHsyncIn = 1'b0;
		wait_out(1'b0, 1'b0, lat);
		wait_out(1'b0, 1'b1, w);
		tick();
		refHsyncIn = 1'b1;
		repeat (60) tick();
	endtask

	// Output levels while reset is held, and enable after release.
	task test_reset();
		int n;
		repeat (7) tick();
		chk("outputEnable", 0, outputEnable);
		chk("horizontalSyncOut", 1, horizontalSyncOut);
		chk("verticalSyncOut", 1, verticalSyncOut);
		chk("compositeOutputBus", 0, compositeOutputBus);
		chk("pixelRateClockOut", 0, pixelRateClockOut);
		reset = 1'b0;
		for (n = 0; n < 20 && outputEnable !== 1'b1; n++) tick();
		chk("outputEnable", 1, outputEnable);
		$display("test_reset done");
	endtask

	// Source select for both settings and the half-rate pixel clock.
	task test_clocks();
		logic p;
		for (int i = 0; i < 3; i++) begin
			clockSourceSelect = (i != 1);
			repeat (4) tick();
			repeat (6) begin
				tick();
				#5;
				chk("doublePixelClock", clockSourceSelect ? internalDoubleClock
					: externalDoubleClockIn, doublePixelClock);
			end
			@(posedge doublePixelClock);
			#1;
			p = pixelRateClockOut;
			repeat (6) begin
				@(posedge doublePixelClock);
				#1;
				chk("pixelRateClockOut", !p, pixelRateClockOut);
				p = pixelRateClockOut;
			end
		end
		$display("test_clocks done");
	endtask

	// Fills the buffer behind a held ancillary word, then drains it.
	task test_stream();
		int n, w;
		tick();
		videoLocked = 1'b1;
		wait_out(1'b0, 1'b1, n);
		repeat (10) tick();
		clearLog = 1'b1;
		tick();
		clearLog = 1'b0;
		put_word(VSO_KIND_FIELD, 8'h11, 1'b1, 1'b1);
		put_word(VSO_KIND_FREQ, 8'h22, 1'b1, 1'b0);
		put_word(VSO_KIND_PHASE, 8'h33, 1'b1, 1'b0);
		for (int k = 0; k < 5; k++)
			put_word(VSO_KIND_VIDEO, 8'ha0 + 8'(k), 1'b0, 1'b0);
		srcValid = 1'b0;
		repeat (10) tick();
		chk("srcReady full", 0, srcReady);
		chk("bytes before sync", 0, i_vso_sink_model.seenCnt);
		ref_line(n, w);
		repeat (100) tick();
		chk("bytes seen", 8, i_vso_sink_model.seenCnt);
		for (int k = 0; k < 8; k++) begin
			chk("byte", (k < 3) ? 8'h11 * (k + 1) : 8'ha0 + k - 3,
				i_vso_sink_model.seenData[k]);
			chk("sync beside byte", k >= 3, i_vso_sink_model.seenHs[k]);
			chk("parity beside byte", k < 3, i_vso_sink_model.seenPar[k]);
			if (k != 0 && k != 3)
				chk("pixel spacing", 1, i_vso_sink_model.seenIdx[k]
					- i_vso_sink_model.seenIdx[k - 1]);
		end
		chk("burst flag set", 1, i_vso_sink_model.seenBurst[0]);
		chk("burst flag clear", 0, i_vso_sink_model.seenBurst[1]);
		chk("fieldParityFlag", 0, fieldParityFlag);
		chk("srcReady empty", 1, srcReady);
		$display("test_stream done");
	endtask

	// Locked sync: pulse after each line, vertical low for three lines.
	task test_locked();
		int lat, w, n;
		ref_line(lat, w);
		chk("hsync latency ok", 1, lat <= 5);
		chk("hsync width", 64, w);
		tick();
		refVsyncIn = 1'b0;
		wait_out(1'b1, 1'b0, n);
		chk("vsync latency ok", 1, n <= 5);
		repeat (20) tick();
		refVsyncIn = 1'b1;
		for (int i = 0; i < 3; i++) begin
			ref_line(lat, w);
			chk("vsync after line", i == 2, verticalSyncOut);
		end
		tick();
		refVsyncIn = 1'b0;
		wait_out(1'b1, 1'b0, n);
		tick();
		videoLocked = 1'b0;
		refVsyncIn = 1'b1;
		// Lock loss needs two sync flops and one more link edge to show.
		repeat (6) tick();
		chk("vsync unlocked", 1, verticalSyncOut);
		$display("test_locked done");
	endtask

	// Free-running pulses over eight lines for one phase setting.
	task test_free(input logic [7:0] s);
		int n, w, g, n64, nShort, nNorm, nLong, reps;
		tick();
		phaseErrorSetting = s;
		repeat (2) begin
			wait_out(1'b0, 1'b1, n);
			wait_out(1'b0, 1'b0, n);
		end
		n64 = 0;
		nShort = 0;
		nNorm = 0;
		nLong = 0;
		// Seven visible pulses span exactly one dropped pulse.
		reps = (s == 8'h89) ? 7 : 8;
		repeat (reps) begin
			wait_out(1'b0, 1'b1, w);
			wait_out(1'b0, 1'b0, g);
			n64 += (w == 64);
			nShort += (w == 8'h89 - s);
			nNorm += (w + g == 1716);
			nLong += (w + g == 3432);
		end
		chk("full pulses", (s == 8'h49) ? 8 : 7, n64);
		chk("eighth pulse", (s == 8'h49) ? 8 : (s == 8'h4a), nShort);
		chk("line periods", (s == 8'h89) ? 6 : 8, nNorm);
		chk("dropped pulses", s == 8'h89, nLong);
		chk("vsync free", 1, verticalSyncOut);
		$display("test_free %h done", s);
	endtask

	// Inputs at time zero, then the scenarios in order.
	initial begin
		{core_clk, internalDoubleClock, externalDoubleClockIn} = 3'h0;
		{reset, clockSourceSelect, refHsyncIn, refVsyncIn} = 4'hf;
		{videoLocked, srcValid, srcFieldParity, srcBurstBlank} = 4'h0;
		phaseErrorSetting = 8'h20;
		srcKind = VSO_KIND_VIDEO;
		srcData = 8'h00;
		clearLog = 1'b0;
		error_cnt = 0;
		checks_done = 0;
		test_reset();
		test_clocks();
		test_stream();
		test_locked();
		test_free(8'h49);
		test_free(8'h4a);
		test_free(8'h89);
		conclude();
	end
endmodule // vso_top_tb
